// [core/bha_pkg.sv]
// constants and types for the bus handoff arbiter
package bha_pkg;
  // internal bus owner codes (one-hot)
  typedef enum logic [2:0] {
    BHA_OWN_CPU = 3'h1,
    BHA_OWN_DTC = 3'h2,
    BHA_OWN_DMA = 3'h4
  } bha_owner_t;

  // external bus owner state (one-hot)
  typedef enum logic [2:0] {
    BHA_EXT_IDLE = 3'h1,
    BHA_EXT_INT  = 3'h2,
    BHA_EXT_REL  = 3'h4
  } bha_ext_t;

  // register byte addresses
  localparam logic [11:0] BHA_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] BHA_ADDR_STATUS = 12'h004;

  // control register field positions
  localparam int BHA_CTRL_REL_EN    = 0;
  localparam int BHA_CTRL_ICR       = 1;
  localparam int BHA_CTRL_CANCEL_OE = 2;
  localparam int BHA_CTRL_INTERLV   = 3;
  localparam int BHA_CTRL_ALL_CLOCK_STOP_ENABLE      = 4;
  localparam int BHA_CTRL_W         = 5;
  localparam logic [BHA_CTRL_W-1:0] BHA_CTRL_RST = 5'h00;
endpackage

// [core/bha_arbiter.sv]
// bus handoff arbiter: internal and external bus arbitration with release handshake
// What this block does
// RULE1: core has lowest priority; transfer controller or dma requests win the bus
// RULE2: core yields only at end of bus cycle; in sleep, on any clock
// RULE3: core keeps bus through split word/longword accesses and multi-cycle stacking
// RULE4: core holds bus in move/block/test-and-set data cycles; block write and next read free
// RULE5: core holds bus from target read to write in bit/memory-operate instructions
// RULE6: transfer controller wins internal bus before asking for the external bus
// RULE7: transfer controller runs on; yields to higher master or core when interleave set
// RULE8: transfer controller never yields during descriptor read, first transfer, writeback
// RULE9: transfer controller releases the bus when its run of cycles ends
// RULE10: dma wins internal bus before asking for the external bus
// RULE11: dma never yields between paired dual-address read and write
// RULE12: dma holds bus for block or burst unless preempted or interleave set
// RULE13: otherwise dma releases the bus at end of every bus cycle; here only on request drop, controller request or interleave turn
// RULE14: low release request reaches arbiter only with release enable and input control set
// RULE15: external release granted only after any external cycle completes
// RULE16: reset puts bus logic in reset state at once, aborting cycles
// RULE17: release halts in all-clock-stop mode; entry deferred until bus recovered
// RULE18: internal masters keep running during release unless they need external access
// RULE19: standby entry while released is deferred until the bus is recovered
// RULE20: release request during standby is not acknowledged until standby exits
// RULE21: acknowledge and cancel request outputs float during standby
// RULE22: cancel request and acknowledge may both be low together
// RULE23: external release request beats external access by internal masters
// RULE24: with cancel output enabled, drive it low on external need, sleep entry, clock write
// RULE25: cancel request returns high at rising acknowledge
// RULE26: interleave alternates core cycles with dma or transfer controller; their order unchanged; here the other master gets two cycles per core cycle
// RULE27: each bus has exactly one owner, held until a permitted release point
`timescale 1ns/1ps
module bha_arbiter
  import bha_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // core
  input  wire logic        cpu_req_i,
  input  wire logic        cpu_ext_i,
  input  wire logic        cpu_cyc_end_i,
  input  wire logic        cpu_lock_i,
  input  wire logic        cpu_sleep_i,
  output logic             cpu_gnt_o,
  // transfer controller
  input  wire logic        dtc_req_i,
  input  wire logic        dtc_ext_i,
  input  wire logic        dtc_cyc_end_i,
  input  wire logic        dtc_lock_i,
  input  wire logic        dtc_run_done_i,
  output logic             dtc_gnt_o,
  // dma engine
  input  wire logic        dma_req_i,
  input  wire logic        dma_ext_i,
  input  wire logic        dma_cyc_end_i,
  input  wire logic        dma_pair_i,
  input  wire logic        dma_block_i,
  output logic             dma_gnt_o,
  // external bus grant to current internal owner
  input  wire logic        ext_cyc_busy_i,
  output logic             ext_gnt_o,
  // power-down requests
  input  wire logic        standby_req_i,
  input  wire logic        clkstop_req_i,
  input  wire logic        clk_set_wr_i,
  input  wire logic        standby_i,
  output logic             standby_go_o,
  output logic             clkstop_go_o,
  // release pins
  input  wire logic        ext_release_request_n_i,
  output logic             ext_release_ack_n_o,
  output logic             ext_release_ack_oe_o,
  output logic             release_cancel_request_n_o,
  output logic             release_cancel_request_oe_o
);

  logic [BHA_CTRL_W-1:0] ctrl_r;
  bha_owner_t            owner_r;
  bha_owner_t            owner_nxt;
  bha_ext_t              ext_r;
  bha_ext_t              ext_nxt;
  logic                  il_turn_r;
  logic                  cancel_n_r;
  logic                  ack_n_d_r;
  logic                  rel_req;
  logic                  ext_need;
  logic                  free_pt;
  logic                  hi_req;
  logic                  apb_acc;
  logic                  wr_ctrl;
  logic                  rd_setup;
  logic [7:0]            status_w;
  logic                  rel_pin;
  logic                  rel_frozen;
  logic                  released;
  logic                  cancel_set;
  logic                  cancel_clr;
  logic                  cpu_free;
  logic                  dtc_free;
  logic                  dma_free;
  logic                  il_give;

  wire logic rel_en    = ctrl_r[BHA_CTRL_REL_EN];
  wire logic icr_bit   = ctrl_r[BHA_CTRL_ICR];
  wire logic cancel_oe = ctrl_r[BHA_CTRL_CANCEL_OE];
  wire logic interlv   = ctrl_r[BHA_CTRL_INTERLV];
  wire logic all_clock_stop_enable      = ctrl_r[BHA_CTRL_ALL_CLOCK_STOP_ENABLE];

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ref_a);
    return a == ref_a;
  endfunction

  // read mux for both mapped words; anything else reads as zero
  function automatic logic [31:0] read_word(input logic [11:0] a, input logic [BHA_CTRL_W-1:0] c,
                                            input logic [7:0] s);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (addr_hit(a, BHA_ADDR_CTRL)) begin
      w[BHA_CTRL_W-1:0] = c;
    end else if (addr_hit(a, BHA_ADDR_STATUS)) begin
      w[7:0] = s;
    end
    return w;
  endfunction

  // next owner once the current one lets go, highest requester first
  function automatic bha_owner_t pick_free(input logic dma_want, input logic dtc_want);
    bha_owner_t o;
    o = BHA_OWN_CPU;
    if (dma_want) begin
      o = BHA_OWN_DMA;
    end else if (dtc_want) begin
      o = BHA_OWN_DTC;
    end
    return o;
  endfunction

  // apb: zero wait states, unmapped addresses flag an error
  assign apb_acc   = psel_i && penable_i;
  assign wr_ctrl   = apb_acc && pwrite_i && addr_hit(paddr_i, BHA_ADDR_CTRL);
  // read data is fetched in setup so it already stands at the access edge
  assign rd_setup  = psel_i && !penable_i && !pwrite_i;
  assign status_w  = {release_cancel_request_n_o, ext_r, owner_r, 1'b0};
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc && !addr_hit(paddr_i, BHA_ADDR_CTRL) && !addr_hit(paddr_i, BHA_ADDR_STATUS);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= BHA_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata_i[BHA_CTRL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_o <= read_word(paddr_i, ctrl_r, status_w);
    end
  end

  // pin request passes only with both enable bits set
  assign rel_pin    = !ext_release_request_n_i && rel_en && icr_bit;                // RULE14
  // clock stop freezes the release logic unless the bus is already out
  assign rel_frozen = all_clock_stop_enable && cpu_sleep_i && clkstop_req_i && ext_r != BHA_EXT_REL; // RULE17
  // standby stops the clock, so a request then waits for the wake-up
  assign rel_req    = rel_pin && !standby_i && !rel_frozen;                        // RULE20

  // core lets go at a cycle end, or on any clock while asleep, never in a locked run
  assign cpu_free = (cpu_cyc_end_i || cpu_sleep_i) && !cpu_lock_i;                // RULE2 RULE3 RULE4 RULE5
  // controller holds through descriptor read, first transfer and write-back
  assign dtc_free = dtc_cyc_end_i && !dtc_lock_i;                                 // RULE8
  // dma never splits a dual-address read from its write
  assign dma_free = dma_cyc_end_i && !dma_pair_i;                                 // RULE11

  // internal owner: release point of whoever holds the bus
  always_comb begin
    free_pt = 1'b0;
    unique case (owner_r)
      BHA_OWN_CPU: free_pt = cpu_free;
      BHA_OWN_DTC: free_pt = dtc_free;
      BHA_OWN_DMA: free_pt = dma_free;
    endcase
  end

  // core gets one turn per two cycles of the other master
  assign il_give = interlv && cpu_req_i && !il_turn_r;                             // RULE26

  always_comb begin
    owner_nxt = owner_r;
    hi_req    = 1'b0;
    unique case (owner_r)
      BHA_OWN_CPU: begin
        // core is lowest: any other request takes the bus at its next release point
        if (free_pt && dma_req_i) begin
          owner_nxt = BHA_OWN_DMA;                                                  // RULE1
        end else if (free_pt && dtc_req_i) begin
          owner_nxt = BHA_OWN_DTC;                                                  // RULE1 RULE6
        end
      end
      BHA_OWN_DTC: begin
        hi_req = dma_req_i;
        // run finished or request gone: hand over by priority
        if (free_pt && (dtc_run_done_i || !dtc_req_i)) begin
          owner_nxt = pick_free(dma_req_i, 1'b0);                                   // RULE9
        end else if (free_pt && hi_req) begin
          owner_nxt = BHA_OWN_DMA;                                                  // RULE7
        end else if (free_pt && il_give) begin
          owner_nxt = BHA_OWN_CPU;                                                  // RULE7 RULE26
        end
      end
      BHA_OWN_DMA: begin
        // block and burst keep the bus only while interleave is off
        if (free_pt && !dma_req_i) begin
          owner_nxt = pick_free(1'b0, dtc_req_i);
        end else if (free_pt && dma_block_i && !interlv) begin
          owner_nxt = BHA_OWN_DMA;                                                  // RULE12
        end else if (free_pt && il_give) begin
          owner_nxt = BHA_OWN_CPU;                                                  // RULE26
        end else if (free_pt && dtc_req_i) begin
          owner_nxt = BHA_OWN_DTC;                                                  // RULE13
        end
      end
    endcase
  end

  // interleave turn: core gets one cycle, then dma or transfer controller gets two
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      il_turn_r <= 1'b0;
    end else if (owner_nxt == BHA_OWN_CPU && owner_r != BHA_OWN_CPU) begin
      il_turn_r <= 1'b1;                                                            // RULE26
    end else if (owner_r != BHA_OWN_CPU && free_pt) begin
      il_turn_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      owner_r <= BHA_OWN_CPU;                                                       // RULE16
    end else begin
      owner_r <= owner_nxt;                                                         // RULE27
    end
  end

  assign cpu_gnt_o = owner_r == BHA_OWN_CPU;
  assign dtc_gnt_o = owner_r == BHA_OWN_DTC;
  assign dma_gnt_o = owner_r == BHA_OWN_DMA;

  // external need only from the master that already owns the internal bus
  always_comb begin
    ext_need = 1'b0;
    unique case (owner_r)
      BHA_OWN_CPU: ext_need = cpu_req_i && cpu_ext_i;
      BHA_OWN_DTC: ext_need = dtc_ext_i;                                            // RULE6
      BHA_OWN_DMA: ext_need = dma_ext_i;                                            // RULE10
    endcase
  end

  // external arbiter
  always_comb begin
    ext_nxt = ext_r;
    unique case (ext_r)
      BHA_EXT_IDLE: begin
        // an outside request beats an inside external access
        if (rel_req) begin
          ext_nxt = BHA_EXT_REL;                                                    // RULE23
        end else if (ext_need) begin
          ext_nxt = BHA_EXT_INT;
        end
      end
      BHA_EXT_INT: begin
        // a running external cycle is never cut short for a release
        if (!ext_cyc_busy_i && rel_req) begin
          ext_nxt = BHA_EXT_REL;                                                    // RULE15 RULE23
        end else if (!ext_cyc_busy_i && !ext_need) begin
          ext_nxt = BHA_EXT_IDLE;
        end
      end
      BHA_EXT_REL: begin
        // bus comes back only when the outside master drops its request
        if (ext_release_request_n_i) begin
          ext_nxt = BHA_EXT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ext_r <= BHA_EXT_IDLE;                                                        // RULE16
    end else begin
      ext_r <= ext_nxt;                                                             // RULE27
    end
  end

  // internal masters continue during release; only external access waits
  assign ext_gnt_o = ext_r == BHA_EXT_INT;                                          // RULE18

  // released lasts until the acknowledge is high again, so the outside
  // master never sees the chip power down while it still holds the bus
  assign released     = ext_r == BHA_EXT_REL || !ack_n_d_r;
  // power-down entry held off while the bus is released
  assign standby_go_o = standby_req_i && !released;                                 // RULE19
  assign clkstop_go_o = clkstop_req_i && all_clock_stop_enable && !released;                         // RULE17

  // ack driven from state; delayed copy finds the rising edge
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ack_n_d_r <= 1'b1;
    end else begin
      ack_n_d_r <= ext_r != BHA_EXT_REL;
    end
  end

  assign cancel_set = cancel_oe && ext_r == BHA_EXT_REL
                      && (ext_need || standby_req_i || clkstop_req_i || clk_set_wr_i); // RULE24
  // ack rises on the edge after the state leaves released
  assign cancel_clr = !ack_n_d_r && ext_r != BHA_EXT_REL;                             // RULE25

  // cancel request: set low on demand, high again when ack rises;
  // set wins, so both may be low together while the ack is still asserted
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cancel_n_r <= 1'b1;
    end else if (cancel_set) begin
      cancel_n_r <= 1'b0;                                                           // RULE24 RULE22
    end else if (cancel_clr) begin
      cancel_n_r <= 1'b1;                                                           // RULE25
    end
  end

  assign ext_release_ack_n_o         = ack_n_d_r;
  assign ext_release_ack_oe_o        = !standby_i;                                  // RULE21
  assign release_cancel_request_n_o  = cancel_n_r;
  assign release_cancel_request_oe_o = cancel_oe && !standby_i;                     // RULE21

endmodule

// [verif/bha_arbiter_asserts.sv]
// port-level checker for the bus handoff arbiter
`timescale 1ns/1ps
module bha_arbiter_asserts (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic cpu_lock_i,
  input wire logic cpu_cyc_end_i,
  input wire logic dma_req_i,
  input wire logic dtc_lock_i,
  input wire logic dma_pair_i,
  input wire logic ext_cyc_busy_i,
  input wire logic ext_release_request_n_i,
  input wire logic standby_i,
  input wire logic cpu_gnt_o,
  input wire logic dtc_gnt_o,
  input wire logic dma_gnt_o,
  input wire logic ext_gnt_o,
  input wire logic standby_go_o,
  input wire logic clkstop_go_o,
  input wire logic ext_release_ack_n_o,
  input wire logic ext_release_ack_oe_o,
  input wire logic release_cancel_request_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_one_owner; $onehot({cpu_gnt_o, dtc_gnt_o, dma_gnt_o}); endproperty
  a_one_owner: assert property (p_one_owner) else $error("internal grant not one-hot");
  property p_dma_wins; cpu_gnt_o && dma_req_i && cpu_cyc_end_i && !cpu_lock_i |=> dma_gnt_o; endproperty
  a_dma_wins: assert property (p_dma_wins) else $error("dma not granted at core cycle end");
  property p_cpu_lock; cpu_gnt_o && cpu_lock_i |=> cpu_gnt_o; endproperty
  a_cpu_lock: assert property (p_cpu_lock) else $error("core lost bus while locked");
  property p_dtc_lock; dtc_gnt_o && dtc_lock_i |=> dtc_gnt_o; endproperty
  a_dtc_lock: assert property (p_dtc_lock) else $error("controller lost bus while locked");
  property p_dma_pair; dma_gnt_o && dma_pair_i |=> dma_gnt_o; endproperty
  a_dma_pair: assert property (p_dma_pair) else $error("dma lost bus inside read-write pair");
  property p_rel_req; $fell(ext_release_ack_n_o) |-> $past(!ext_release_request_n_i, 2); endproperty
  a_rel_req: assert property (p_rel_req) else $error("acknowledge without request");
  property p_rel_busy; $fell(ext_release_ack_n_o) |-> $past(!ext_cyc_busy_i, 2); endproperty
  a_rel_busy: assert property (p_rel_busy) else $error("release during external cycle");
  property p_reset;
    disable iff (1'b0) sys_rst_i |=> cpu_gnt_o && !ext_gnt_o && ext_release_ack_n_o;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state not entered");
  property p_float; standby_i |-> !ext_release_ack_oe_o && !release_cancel_request_oe_o; endproperty
  a_float: assert property (p_float) else $error("release pins driven in standby");
  property p_defer; !ext_release_ack_n_o |-> !standby_go_o && !clkstop_go_o; endproperty
  a_defer: assert property (p_defer) else $error("power-down entered while released");
  // request still low and ack held: nobody inside may drive the pins
  property p_excl;
    !ext_release_ack_n_o && $past(!ext_release_ack_n_o) && !ext_release_request_n_i |-> !ext_gnt_o;
  endproperty
  a_excl: assert property (p_excl) else $error("external bus granted while released");
  c_dma: cover property ($rose(dma_gnt_o));
  c_ack: cover property ($fell(ext_release_ack_n_o));
  c_sb: cover property (standby_i && !ext_release_request_n_i);
endmodule
bind bha_arbiter bha_arbiter_asserts u_bha_arbiter_asserts (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cpu_lock_i(cpu_lock_i), .cpu_cyc_end_i(cpu_cyc_end_i),
  .dma_req_i(dma_req_i), .dtc_lock_i(dtc_lock_i), .dma_pair_i(dma_pair_i), .ext_cyc_busy_i(ext_cyc_busy_i),
  .ext_release_request_n_i(ext_release_request_n_i), .standby_i(standby_i), .cpu_gnt_o(cpu_gnt_o),
  .dtc_gnt_o(dtc_gnt_o), .dma_gnt_o(dma_gnt_o), .ext_gnt_o(ext_gnt_o), .standby_go_o(standby_go_o),
  .clkstop_go_o(clkstop_go_o), .ext_release_ack_n_o(ext_release_ack_n_o),
  .ext_release_ack_oe_o(ext_release_ack_oe_o), .release_cancel_request_oe_o(release_cancel_request_oe_o));

// [verif/bha_ext_master.sv]
// outside bus master model asking for the external bus
`timescale 1ns/1ps
module bha_ext_master (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // bench command and acknowledge pin
  input  wire logic want_i,
  input  wire logic ack_n_i,
  input  wire logic ack_oe_i,
  output logic      req_n_o,
  output logic      owned_o
);
  always @(posedge ref_clk_i) begin
    req_n_o <= sys_rst_i ? 1'b1 : !want_i;
  end
  // a floating acknowledge never counts as a grant
  assign owned_o = ack_oe_i && !ack_n_i;
endmodule

// [verif/testbench.sv]
// self-checking bench for the bus handoff arbiter
`timescale 1ns/1ps
module testbench;
  import bha_pkg::*;
  logic        ref_clk_i, sys_rst_i, psel, pen, pwr, want, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, cpu_req, dtc_req, dma_req, cpu_lock, dtc_lock, dma_pair, dma_block;
  logic        run_done, cyc_end, dma_ext, busy, sb_req, sb, req_n, ack_n, ack_oe, can_n, can_oe;
  logic        cpu_gnt, dtc_gnt, dma_gnt, ext_gnt, sb_go, cs_go, owned;
  int          failures, cmp_count, i;
  logic [11:0] rows [9];
  bha_arbiter u_bha_arbiter (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .cpu_req_i(cpu_req), .cpu_ext_i(1'b0), .cpu_cyc_end_i(cyc_end), .cpu_lock_i(cpu_lock),
    .cpu_sleep_i(1'b0), .cpu_gnt_o(cpu_gnt), .dtc_req_i(dtc_req), .dtc_ext_i(1'b0), .dtc_cyc_end_i(cyc_end),
    .dtc_lock_i(dtc_lock), .dtc_run_done_i(run_done), .dtc_gnt_o(dtc_gnt), .dma_req_i(dma_req),
    .dma_ext_i(dma_ext), .dma_cyc_end_i(cyc_end), .dma_pair_i(dma_pair), .dma_block_i(dma_block),
    .dma_gnt_o(dma_gnt), .ext_cyc_busy_i(busy), .ext_gnt_o(ext_gnt), .standby_req_i(sb_req),
    .clkstop_req_i(1'b0), .clk_set_wr_i(1'b0), .standby_i(sb), .standby_go_o(sb_go), .clkstop_go_o(cs_go),
    .ext_release_request_n_i(req_n), .ext_release_ack_n_o(ack_n), .ext_release_ack_oe_o(ack_oe),
    .release_cancel_request_n_o(can_n), .release_cancel_request_oe_o(can_oe));
  bha_ext_master u_bha_ext_master (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .want_i(want),
    .ack_n_i(ack_n), .ack_oe_i(ack_oe), .req_n_o(req_n), .owned_o(owned));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk_i);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    {psel, pen} <= 2'b00;
    if (n >= 20) begin
      failures++;
      print_verdict();
    end
  endtask
  // one cycle-end pulse seen by every master
  task automatic cyc_pulse();
    @(posedge ref_clk_i);
    cyc_end <= 1'b1;
    @(posedge ref_clk_i);
    cyc_end <= 1'b0;
    #1;
  endtask
  // bounded wait on the partner's view of ownership
  task automatic wait_own(logic v);
    int n;
    n = 0;
    while (owned !== v && n < 20) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 20) begin
      failures++;
      print_verdict();
    end
    #1;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {psel, pen, pwr, paddr, pwdata, want, dma_ext, busy, sb_req, sb} = '0;
    {cpu_req, dtc_req, dma_req, cpu_lock, dtc_lock, dma_pair, dma_block, run_done, cyc_end} = '0;
    failures = 0;
    cmp_count = 0;
    rows = '{12'hB09, 12'hA0C, 12'h44C, 12'h40A, 12'hE8A, 12'h819, 12'hC0A, 12'h60C, 12'h62C};
    sys_rst_i = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    #1 chk("cpu_gnt", 32'(cpu_gnt), 32'h1);
    for (i = 0; i < 9; i++) begin
      @(posedge ref_clk_i);
      {cpu_req, dtc_req, dma_req, cpu_lock, dtc_lock, dma_pair, dma_block, run_done, cyc_end} <= rows[i][11:3];
      @(posedge ref_clk_i);
      cyc_end <= 1'b0;
      #1 chk("gnt", 32'({dma_gnt, dtc_gnt, cpu_gnt}), 32'(rows[i][2:0]));
    end
    $display("arbitration table done");
    apb(1'b0, BHA_ADDR_CTRL, 32'h0);
    chk("ctrl_rst", rd, 32'h0);
    {want, busy, dma_ext, sb_req} <= 4'hF;
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    chk("gate_off", 32'(owned), 32'h0);
    apb(1'b1, BHA_ADDR_CTRL, 32'h07);
    apb(1'b0, BHA_ADDR_CTRL, 32'h0);
    chk("ctrl", rd, 32'h07);
    repeat (3) @(posedge ref_clk_i);
    #1 chk("busy_hold", 32'(owned), 32'h0);
    @(posedge ref_clk_i);
    busy <= 1'b0;
    wait_own(1'b1);
    repeat (2) @(posedge ref_clk_i);
    #1 chk("rel", {can_n, ext_gnt, sb_go, dma_gnt}, 32'h1);
    @(posedge ref_clk_i);
    want <= 1'b0;
    wait_own(1'b0);
    @(posedge ref_clk_i);
    #1 chk("recover", {can_n, sb_go}, 32'h3);
    $display("release handshake done");
    @(posedge ref_clk_i);
    {sb, sb_req, want} <= 3'b101;
    repeat (4) @(posedge ref_clk_i);
    #1 chk("standby", {ack_oe, can_oe, ack_n}, 32'h1);
    @(posedge ref_clk_i);
    sb <= 1'b0;
    wait_own(1'b1);
    chk("after_sb", 32'(owned), 32'h1);
    $display("standby done");
    apb(1'b1, BHA_ADDR_CTRL, 32'h0F);
    cpu_req <= 1'b1;
    cyc_pulse();
    chk("il_cpu", 32'({dma_gnt, cpu_gnt}), 32'h1);
    cyc_pulse();
    chk("il_back", 32'({dma_gnt, cpu_gnt}), 32'h2);
    $display("interleave done");
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    #1 chk("mid_rst", {cpu_gnt, dma_gnt, ack_n}, 32'h5);
    $display("mid-run reset done");
    print_verdict();
  end
endmodule
